// ==== design/vmac_pkg.sv ====
// Package for the eight-lane vector multiply-accumulate engine
package vmac_pkg;

   // ****************************************************************
   // Widths and counts
   // ****************************************************************
   localparam int unsigned NUM_LANES   = 8;
   localparam int unsigned LANE_AW     = 3;
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned PROD_W      = 16;
   localparam int unsigned SUM_W       = 19;
   localparam int unsigned OUT_CHUNKS  = 3;

   // ****************************************************************
   // Command byte layout
   // ****************************************************************
   localparam int unsigned OPC_LSB     = 6;
   localparam int unsigned OPC_MSB     = 7;
   localparam int unsigned ADDR_LSB    = 0;
   localparam int unsigned ADDR_MSB    = 5;

   typedef enum logic [1:0] {
      VMAC_OP_LOAD_W = 2'h0,
      VMAC_OP_LOAD_A = 2'h1,
      VMAC_OP_READ   = 2'h2,
      VMAC_OP_NOP    = 2'h3
   } vmac_op_t;

   typedef struct packed {
      vmac_op_t   opcode;
      logic [5:0] addr;
   } vmac_cmd_t;

   // Reset values
   localparam logic [7:0]  OPERAND_RST = 8'h00;
   localparam logic [7:0]  RESULT_RST  = 8'h00;

endpackage : vmac_pkg

// ==== design/vmac_top.sv ====
// Vector multiply-accumulate engine with adder tree and byte readout
`timescale 1ns/1ps

// Functional notes
// - Eight multiply units, each with its own weight and activation register
// - Opcode 00 writes operand byte into addressed unit's weight register
// - Opcode 01 writes operand byte into addressed unit's activation register
// - Each unit multiplies its weight by activation, product feeds summation
// - Three-level pairwise adder tree sums all eight products, no precision loss
// - Final sum is 19 bits wide and returned whole by the readout
// - Opcode 10 starts a readout of the accumulated sum
// - Readout gives three bytes on output port, most significant first
// - Low command bits select the unit; each unit individually addressable
// - Command and operand held one cycle, captured on that clock edge
// - Weights persist across operations; new activations reuse them
module vmac_top (
   input  wire logic                    I_CLK,
   input  wire logic                    I_RESET_N,
   input  wire vmac_pkg::vmac_cmd_t     I_COMMAND_BYTE_IN,
   input  wire logic [7:0]              I_OPERAND_IN,
   output logic      [7:0]              O_RESULT_BYTE_OUT,
   output logic      [7:0]              O_OPERAND_OE
);
   import vmac_pkg::*;

   // ****************************************************************
   // Operand registers
   // ****************************************************************
   // eight unit registers
   logic [DATA_W-1:0] weight_q [NUM_LANES];
   logic [DATA_W-1:0] weight_d [NUM_LANES];
   logic [DATA_W-1:0] act_q    [NUM_LANES];
   logic [DATA_W-1:0] act_d    [NUM_LANES];

   // unit decode
   // Addresses beyond the eighth unit hit nothing
   function automatic logic lane_hit(input logic [5:0] addr, input int unsigned lane);
      lane_hit = (addr == 6'(lane));
   endfunction : lane_hit

   genvar g;
   generate
      for (g = 0; g < NUM_LANES; g++) begin : g_lane
         always_comb begin
            weight_d[g] = weight_q[g];
            act_d[g]    = act_q[g];
            if (lane_hit(I_COMMAND_BYTE_IN.addr, g)) begin
               if (I_COMMAND_BYTE_IN.opcode == VMAC_OP_LOAD_W) begin
                  weight_d[g] = I_OPERAND_IN;
               end
               else if (I_COMMAND_BYTE_IN.opcode == VMAC_OP_LOAD_A) begin
                  act_d[g] = I_OPERAND_IN;
               end
            end
         end

         // capture on edge; weights only change on load or reset
         always_ff @(posedge I_CLK) begin
            if (!I_RESET_N) begin
               weight_q[g] <= OPERAND_RST;
               act_q[g]    <= OPERAND_RST;
            end else begin
               weight_q[g] <= weight_d[g];
               act_q[g]    <= act_d[g];
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Products and adder tree
   // ****************************************************************
   logic [PROD_W-1:0]  prod   [NUM_LANES];
   logic [PROD_W:0]    lvl1   [4];
   logic [PROD_W+1:0]  lvl2   [2];
   logic [SUM_W-1:0]   sum_tree;

   generate
      for (g = 0; g < NUM_LANES; g++) begin : g_mul
         assign prod[g] = PROD_W'(weight_q[g]) * PROD_W'(act_q[g]);
      end
      for (g = 0; g < 4; g++) begin : g_l1
         assign lvl1[g] = {1'b0, prod[2*g]} + {1'b0, prod[2*g+1]};
      end
      for (g = 0; g < 2; g++) begin : g_l2
         assign lvl2[g] = {1'b0, lvl1[2*g]} + {1'b0, lvl1[2*g+1]};
      end
   endgenerate

   assign sum_tree = {1'b0, lvl2[0]} + {1'b0, lvl2[1]};

   // ****************************************************************
   // Readout sequencer
   // ****************************************************************
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_GAP,
      ST_HI,
      ST_MID,
      ST_LO
   } vmac_rd_t;

   vmac_rd_t          state_q, state_d;
   logic [SUM_W-1:0]  snap_q, snap_d;
   logic [7:0]        out_q, out_d;

   always_comb begin
      state_d = state_q;
      snap_d  = snap_q;
      out_d   = out_q;
      case (state_q)
         ST_GAP: begin
            out_d   = 8'(snap_q >> 16);
            state_d = ST_HI;
         end
         ST_HI: begin
            out_d   = snap_q[15:8];
            state_d = ST_MID;
         end
         ST_MID: begin
            out_d   = snap_q[7:0];
            state_d = ST_LO;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      // only opcode 10 starts a readout, restarting any in flight
      if (I_COMMAND_BYTE_IN.opcode == VMAC_OP_READ) begin
         snap_d  = sum_tree;
         state_d = ST_GAP;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RESET_N) begin
         state_q <= ST_IDLE;
         snap_q  <= '0;
         out_q   <= RESULT_RST;
      end else begin
         state_q <= state_d;
         snap_q  <= snap_d;
         out_q   <= out_d;
      end
   end

   assign O_RESULT_BYTE_OUT = out_q;
   // Operand pins are input only
   assign O_OPERAND_OE      = 8'h00;

endmodule : vmac_top

// ==== tb/vmac_host.sv ====
// Host driver model issuing command bytes
`timescale 1ns/1ps
module vmac_host (
   input  wire logic           I_CLK,
   input  wire logic [7:0]     i_res,
   output vmac_pkg::vmac_cmd_t o_cmd,
   output logic      [7:0]     o_opd
);
   import vmac_pkg::*;
   initial begin
      o_cmd = '{VMAC_OP_NOP, 6'h00};
      o_opd = 8'h5a;
   end
   task automatic issue(input vmac_op_t op, input logic [5:0] ad, input logic [7:0] d);
      @(posedge I_CLK) #1;
      o_cmd = '{op, ad};
      // Unused operand toggles so stale data never looks valid
      o_opd = (op inside {VMAC_OP_LOAD_W, VMAC_OP_LOAD_A}) ? d : ~o_opd;
   endtask : issue
   task automatic read_sum(output logic [23:0] r);
      issue(VMAC_OP_READ, 6'h00, 8'h00);
      issue(VMAC_OP_NOP, 6'h00, 8'h00);
      r = 24'h000000;
      // First byte stands from the edge that took the no-operation cycle
      repeat (3) begin
         @(posedge I_CLK) #1;
         r = {r[15:0], i_res};
      end
   endtask : read_sum
endmodule : vmac_host

// ==== tb/vmac_chk_sva.sv ====
// Port checks for the vector engine readout
`timescale 1ns/1ps
module vmac_chk import vmac_pkg::*; (
   input wire logic       I_CLK,
   input wire logic       I_RESET_N,
   input wire vmac_cmd_t  I_COMMAND_BYTE_IN,
   input wire logic [7:0] I_OPERAND_IN,
   input wire logic [7:0] O_RESULT_BYTE_OUT,
   input wire logic [7:0] O_OPERAND_OE
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   wire vmac_op_t op = I_COMMAND_BYTE_IN.opcode;
   sequence s_rd;
      op == VMAC_OP_READ ##1 op != VMAC_OP_READ;
   endsequence
   property p_rst;
      disable iff (1'b0) !I_RESET_N |=> O_RESULT_BYTE_OUT == 8'h00;
   endproperty
   property p_oe;
      O_OPERAND_OE == 8'h00;
   endproperty
   property p_top;
      s_rd |=> O_RESULT_BYTE_OUT[7:3] == 5'h00;
   endproperty
   property p_nop;
      (op == VMAC_OP_NOP) [*6] |-> $stable(O_RESULT_BYTE_OUT);
   endproperty
   property p_ldw;
      (op == VMAC_OP_LOAD_W) [*6] |-> $stable(O_RESULT_BYTE_OUT);
   endproperty
   property p_lda;
      (op == VMAC_OP_LOAD_A) [*6] |-> $stable(O_RESULT_BYTE_OUT);
   endproperty
   property p_chg;
      $changed(O_RESULT_BYTE_OUT) |-> $past(op == VMAC_OP_READ, 2)
         || $past(op == VMAC_OP_READ, 3) || $past(op == VMAC_OP_READ, 4);
   endproperty
   a_rst: assert property (p_rst) else $error("out not clear in reset");
   a_oe: assert property (p_oe) else $error("operand pins driven");
   a_top: assert property (p_top) else $error("top byte not padded");
   a_nop: assert property (p_nop) else $error("nop moved output");
   a_ldw: assert property (p_ldw) else $error("weight load moved output");
   a_lda: assert property (p_lda) else $error("act load moved output");
   a_chg: assert property (p_chg) else $error("output changed unasked");
endmodule : vmac_chk

// ==== tb/tb_top.sv ====
// Top-level bench for the vector engine
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin num_checks++; if ((sn) !== (ex)) begin error_cnt++; \
   $display("BAD %s exp %h got %h", nm, ex, sn); end end
module tb_top;
   import vmac_pkg::*;
   logic        clk;
   logic        rst_n;
   vmac_cmd_t   cmd;
   logic [7:0]  opd;
   logic [7:0]  res;
   logic [23:0] r;
   int          error_cnt = 0;
   int          num_checks = 0;
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   vmac_host vmac_host_inst (.I_CLK(clk), .i_res(res), .o_cmd(cmd), .o_opd(opd));
   vmac_top vmac_top_inst (.I_CLK(clk), .I_RESET_N(rst_n), .I_COMMAND_BYTE_IN(cmd),
      .I_OPERAND_IN(opd), .O_RESULT_BYTE_OUT(res), .O_OPERAND_OE());
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out
   task automatic t_full();
      for (int i = 0; i < 8; i++) vmac_host_inst.issue(VMAC_OP_LOAD_W, 6'(i), 8'hff);
      for (int i = 0; i < 8; i++) vmac_host_inst.issue(VMAC_OP_LOAD_A, 6'(i), 8'hff);
      // Address eight must not alias unit zero
      vmac_host_inst.issue(VMAC_OP_LOAD_W, 6'h08, 8'h00);
      vmac_host_inst.read_sum(r);
      `CHK("full sum", 24'h07f008, r)
   endtask : t_full
   task automatic t_reuse();
      for (int i = 0; i < 8; i++) vmac_host_inst.issue(VMAC_OP_LOAD_A, 6'(i), 8'(i + 1));
      vmac_host_inst.issue(VMAC_OP_LOAD_W, 6'h03, 8'h00);
      vmac_host_inst.issue(VMAC_OP_NOP, 6'h03, 8'h55);
      vmac_host_inst.read_sum(r);
      `CHK("reuse sum", 24'h001fe0, r)
   endtask : t_reuse
   initial begin
      rst_n = 1'b0;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      `CHK("reset out", 8'h00, res)
      t_full();
      t_reuse();
      repeat (8) @(posedge clk);
      close_out();
   end
   initial begin
      #100us;
      error_cnt++;
      close_out();
   end
endmodule : tb_top
bind vmac_top vmac_chk vmac_chk_inst (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
   .I_COMMAND_BYTE_IN(I_COMMAND_BYTE_IN), .I_OPERAND_IN(I_OPERAND_IN),
   .O_RESULT_BYTE_OUT(O_RESULT_BYTE_OUT), .O_OPERAND_OE(O_OPERAND_OE));
